// file: fan_pin_gpio_status_tb.sv
// self-checking bench for the repurposed fan-drive pin logic.
// assumes the byte register port with one-clock read latency.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin \
	n_compared++; \
	if ((gt) !== (ex)) begin \
		err_count++; \
		$display("ERROR %s exp %h got %h", nm, ex, gt); \
	end \
end

module fan_pin_gpio_status_tb;
	import fpg_pkg::*;
	logic clk_sys_i, reset_i, reg_wr;
	logic [7:0] reg_addr, reg_wdata, rdata, v, en_b, cfg_b, wv;
	logic [3:0] fan_drive, pin_level, pin_out, pin_oe, board_drv, st, exp_oe, exp_out;
	logic [31:0] seed, r;
	int err_count, n_compared, cycles;

	fpg_gpio #(.NUM_PINS(4)) DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
		.reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata), .fan_drive_i(fan_drive),
		.pin_in_i(pin_level), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
	fpg_board_model board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .board_drv_i(board_drv),
		.pin_level_o(pin_level));

	// ------------------------------------------------------------
	// clock, timeout and helpers
	// ------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// the whole run needs about 870 cycles; 5000 leaves slack
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected state byte: enabled pins only, output bit or qualified input
	function automatic logic [7:0] exp_state(input logic [7:0] en, cfg, input logic [3:0] s, lvl);
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < 4; i++) begin
			if (en[3-i]) e[4+i] = cfg[7-2*i] ? s[i] : (cfg[6-2*i] ? lvl[i] : ~lvl[i]);
		end
		return e;
	endfunction
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr <= a;
		@(posedge clk_sys_i);
		#1 d = rdata;
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset_i = 1'b1;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		fan_drive = 4'h0;
		board_drv = 4'h0;
		seed = 32'd85379;
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		st = 4'h0;
		repeat (10) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(FPG_OFS_PIN_STATE, v);
		`CHK("pin_state reset", FPG_RST_PIN_STATE, v)
		rd(FPG_OFS_REPURPOSE, v);
		`CHK("repurpose reset", FPG_RST_REPURPOSE, v)
		rd(FPG_OFS_PIN_CFG, v);
		`CHK("pin_cfg reset", FPG_RST_PIN_CFG, v)
		$display("test reset done");
		// corners first: all outputs high, all inputs low, nothing repurposed
		for (int k = 0; k < 60; k++) begin
			r = rnd();
			@(posedge clk_sys_i);
			fan_drive <= r[23:20];
			// corner 1 holds every released pin low so active-low inputs all read set
			board_drv <= (k == 1) ? 4'h0 : r[27:24];
			en_b = r[7:0];
			cfg_b = r[15:8];
			wv = {r[19:16], 4'h0}; // test bits left at zero
			if (k == 0) begin
				en_b = 8'h0f;
				cfg_b = 8'hff;
				wv = 8'hf0;
			end
			if (k == 1) begin
				en_b = 8'h0f;
				cfg_b = 8'h00;
				wv = 8'hf0;
			end
			if (k == 2) en_b = 8'h00;
			wr(FPG_OFS_REPURPOSE, en_b);
			wr(FPG_OFS_PIN_CFG, cfg_b);
			wr(FPG_OFS_PIN_STATE, wv);
			for (int i = 0; i < 4; i++) begin
				if (cfg_b[7-2*i]) st[i] = wv[4+i];
				exp_oe[i] = !en_b[3-i] || cfg_b[7-2*i];
				exp_out[i] = !en_b[3-i] ? fan_drive[i] : (cfg_b[6-2*i] ? st[i] : ~st[i]);
			end
			repeat (3) @(posedge clk_sys_i);
			rd(FPG_OFS_PIN_STATE, v);
			`CHK("pin_state", exp_state(en_b, cfg_b, st, board_drv), v)
			`CHK("pin_oe", exp_oe, pin_oe)
			`CHK("pin_out", exp_out & exp_oe, pin_out & exp_oe)
			rd(FPG_OFS_PIN_CFG, v);
			`CHK("pin_cfg", cfg_b, v)
		end
		$display("test random done");
		// second reset in mid-run: state must clear and pins fall back to fan drive
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		st = 4'h0;
		rd(FPG_OFS_PIN_STATE, v);
		`CHK("pin_state mid reset", FPG_RST_PIN_STATE, v)
		`CHK("pin_oe mid reset", 4'hf, pin_oe)
		`CHK("pin_out mid reset", fan_drive, pin_out)
		rd(FPG_OFS_REPURPOSE, v);
		`CHK("repurpose mid reset", FPG_RST_REPURPOSE, v)
		$display("test mid reset done");
		wr(8'h55, 8'ha5);
		rd(8'h55, v);
		`CHK("unmapped", FPG_RDATA_UNMAPPED, v)
		$display("test unmapped done");
		print_verdict();
	end
endmodule // fan_pin_gpio_status_tb

`default_nettype wire

// file: fpg_board_model.sv
// board-side model of the four repurposed fan-drive pins.
// assumes the block drives a pin only while its enable output is high.
`timescale 1ns/1ns
`default_nettype none

module fpg_board_model (
	input wire logic [3:0] pin_out_i, // level from the block
	input wire logic [3:0] pin_oe_i, // block drive enable
	input wire logic [3:0] board_drv_i, // level board logic puts on released pins
	output logic [3:0] pin_level_o // resolved wire level
);
	// ------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------
	// a released pin shows the board level, never the block's stale drive
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level_o[i] = pin_oe_i[i] ? pin_out_i[i] : board_drv_i[i];
		end
	end
endmodule // fpg_board_model

`default_nettype wire

// file: fpg_gpio.sv
// top of the repurposed fan-drive pin logic: config and state registers,
// pin steering between fan drive and general-purpose use.
// assumes the serial-port decoder issues one-cycle byte writes and holds
// the read offset; read data follows one clock after the offset.
// Notes on behaviour
// - state bits 7:4 show a pin's state only while that pin is repurposed.
// - bit 7 is pin 4, bit 6 pin 3, bit 5 pin 2, bit 4 pin 1.
// - input pin: state bit read-only, set while input is asserted.
// - polarity bit picks high or low as asserted, for inputs and outputs.
// - output pin: state bit read/write; a one drives the asserted level.
// - bits 3:0 are test bits without function; software leaves them alone.
// - pin state register reads all zeros after reset.
// - enable bits 3..0 of offset 0x7f turn drive outputs 1..4 into pins.
// - direction bit one means output, zero means input.
// - polarity bit one means active high, zero active low.
`timescale 1ns/1ns
`default_nettype none

module fpg_gpio #(
	parameter int NUM_PINS = fpg_pkg::FPG_NUM_PINS
) (
	input wire logic clk_sys_i, // device clock, 10 MHz
	input wire logic reset_i, // synchronous, active high
	input wire logic [7:0] reg_addr_i, // register offset
	input wire logic reg_wr_i, // one-cycle write strobe
	input wire logic [7:0] reg_wdata_i, // write data
	output logic [7:0] reg_rdata_o, // read data, one clock after offset
	input wire logic [NUM_PINS-1:0] fan_drive_i, // drive from fan pwm logic
	input wire logic [NUM_PINS-1:0] pin_in_i, // pin levels, index 0 = pin 1
	output logic [NUM_PINS-1:0] pin_out_o, // level driven onto the pins
	output logic [NUM_PINS-1:0] pin_oe_o // high while the pin is driven
);
	import fpg_pkg::*;

	logic [7:0] repurpose_q;
	logic [7:0] pin_cfg_q;
	logic [NUM_PINS-1:0] out_state_q;
	logic [3:0] test_bits_q;
	logic [NUM_PINS-1:0] en;
	logic [NUM_PINS-1:0] dir;
	logic [NUM_PINS-1:0] pol;
	logic [NUM_PINS-1:0] in_asserted;
	logic [NUM_PINS-1:0] state_view;
	logic [7:0] state_byte;
	logic [7:0] rdata_d;
	logic wr_state;

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	// pick a bit counting down from msb by a fixed step per pin
	function automatic logic pick_bit(input logic [7:0] value, input int msb, input int step, input int pin);
		pick_bit = value[msb - step * pin];
	endfunction

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			en[i] = pick_bit(repurpose_q, FPG_EN_MSB, 1, i);
			dir[i] = pick_bit(pin_cfg_q, FPG_DIR_MSB, 2, i);
			pol[i] = pick_bit(pin_cfg_q, FPG_POL_MSB, 2, i);
		end
	end

	// ------------------------------------------------------------
	// input sensing
	// ------------------------------------------------------------
	fpg_pin_sync #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.level_i(pin_in_i),
		.pol_i(pol),
		.asserted_o(in_asserted)
	);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// upper nibble of the enable register is kept as plain storage
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			repurpose_q <= FPG_RST_REPURPOSE;
			pin_cfg_q <= FPG_RST_PIN_CFG;
		end else if (reg_wr_i) begin
			if (reg_addr_i == FPG_OFS_REPURPOSE)
				repurpose_q <= reg_wdata_i;
			if (reg_addr_i == FPG_OFS_PIN_CFG)
				pin_cfg_q <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// pin state register
	// ------------------------------------------------------------
	assign wr_state = reg_wr_i && (reg_addr_i == FPG_OFS_PIN_STATE);

	// output bits take writes only for output pins; input pins keep tracking
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			out_state_q <= FPG_RST_PIN_STATE[FPG_STATE_LSB +: NUM_PINS];
		end else if (wr_state) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (dir[i])
					out_state_q[i] <= reg_wdata_i[FPG_STATE_LSB + i];
			end // input pins ignore the write
		end
	end

	// test bits are stored and read back but steer nothing
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			test_bits_q <= FPG_RST_PIN_STATE[3:0];
		else if (wr_state)
			test_bits_q <= reg_wdata_i[3:0];
	end

	// visible state: zero unless repurposed, else sensed or written value
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++)
			state_view[i] = en[i] && (dir[i] ? out_state_q[i] : in_asserted[i]);
		state_byte = {state_view, test_bits_q};
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		unique case (reg_addr_i)
			FPG_OFS_REPURPOSE: rdata_d = repurpose_q;
			FPG_OFS_PIN_CFG: rdata_d = pin_cfg_q;
			FPG_OFS_PIN_STATE: rdata_d = state_byte;
			default: rdata_d = FPG_RDATA_UNMAPPED;
		endcase
	end

	// registered so the serial shifter sees a stable byte
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			reg_rdata_o <= FPG_RDATA_UNMAPPED;
		else
			reg_rdata_o <= rdata_d;
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// registered drive avoids glitches while config bits change together
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_out_o <= '0;
			pin_oe_o <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (!en[i]) begin
					pin_out_o[i] <= fan_drive_i[i];
					pin_oe_o[i] <= 1'b1;
				end else begin
					pin_out_o[i] <= ~(out_state_q[i] ^ pol[i]);
					pin_oe_o[i] <= dir[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence seq_out_write(int i);
		wr_state && en[i] && dir[i];
	endsequence

	sequence seq_cfg_stable(int i);
		##1 (en[i] && dir[i] && $stable(pol[i]));
	endsequence

	chk_unused_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(state_view & ~en) == '0)
		else $error("state bit set for a pin not repurposed");

	chk_input_track: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		((state_view ^ in_asserted) & en & ~dir) == '0)
		else $error("input state bit does not follow sensed input");

	chk_pin4_order: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		seq_out_write(3) ##0 seq_cfg_stable(3) ##1 (en[3] && !$changed(pol[3]))
		|-> pin_out_o[3] == ~($past(reg_wdata_i[7], 2) ^ pol[3]))
		else $error("bit 7 write did not reach pin 4");

	chk_pin1_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		seq_out_write(0) ##0 seq_cfg_stable(0) |=> pin_out_o[0] == ~($past(reg_wdata_i[4], 2) ^ $past(pol[0])))
		else $error("bit 4 write did not drive pin 1 correctly");

	chk_input_ignore: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(wr_state && !dir[1]) |=> $stable(out_state_q[1]))
		else $error("write changed an input pin state");

	chk_reset_zero: assert property (@(posedge clk_sys_i)
		reset_i |=> (state_byte == 8'h00 && reg_rdata_o == 8'h00) or reset_i)
		else $error("pin state not zero after reset");

	chk_test_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		wr_state |=> state_byte[3:0] == $past(reg_wdata_i[3:0]))
		else $error("test bits not kept");

	chk_fan_pass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!en[2] |=> (pin_out_o[2] == $past(fan_drive_i[2]) && pin_oe_o[2]))
		else $error("fan drive not passed to pin 3");

	chk_input_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(en[0] && !dir[0]) |=> !pin_oe_o[0])
		else $error("input pin still driven");

	chk_polarity_sense: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(en[1] && !dir[1] && !pol[1]) |-> state_view[1] == ~u_sync.level_q[1])
		else $error("active-low input sensed with wrong sense");

endmodule // fpg_gpio

`default_nettype wire

// file: fpg_pin_sync.sv
// two-flop synchroniser for the repurposed pins plus polarity qualifier.
// assumes pin levels arrive asynchronously; polarity is a same-clock level.
`timescale 1ns/1ns
`default_nettype none

module fpg_pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk_sys_i, // device clock
	input wire logic reset_i, // synchronous, active high
	input wire logic [WIDTH-1:0] level_i, // raw pin levels
	input wire logic [WIDTH-1:0] pol_i, // 1 = active high
	output logic [WIDTH-1:0] asserted_o // pin in its asserted condition
);
	import fpg_pkg::*;

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] level_q;

	// ------------------------------------------------------------
	// synchroniser: first stage feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			meta_q <= '0;
			level_q <= '0;
		end else begin
			meta_q <= level_i;
			level_q <= meta_q;
		end
	end

	// active-low pins count as asserted while low
	assign asserted_o = ~(level_q ^ pol_i);

endmodule // fpg_pin_sync

`default_nettype wire

// file: fpg_pkg.sv
// constants for the repurposed fan-drive pin logic: register offsets,
// field positions and values after reset.
// assumes a byte-wide register port driven by the device's serial port logic.
package fpg_pkg;

	// ------------------------------------------------------------
	// register offsets on the byte-wide register port
	// ------------------------------------------------------------
	localparam logic [7:0] FPG_OFS_REPURPOSE = 8'h7f; // low nibble: repurpose enables
	localparam logic [7:0] FPG_OFS_PIN_CFG = 8'h80; // direction and polarity pairs
	localparam logic [7:0] FPG_OFS_PIN_STATE = 8'h81; // pin_state register

	// ------------------------------------------------------------
	// field positions and sizes
	// ------------------------------------------------------------
	localparam int FPG_NUM_PINS = 4; // repurposable fan-drive pins
	localparam int FPG_EN_MSB = 3; // pin1 enable bit, pin4 at bit 0
	localparam int FPG_DIR_MSB = 7; // pin1 direction bit, then two bits per pin
	localparam int FPG_POL_MSB = 6; // pin1 polarity bit, then two bits per pin
	localparam int FPG_STATE_LSB = 4; // pin1 state bit, pin4 at bit 7
	localparam int FPG_SYNC_STAGES = 2; // flops on each pin before use

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] FPG_RST_REPURPOSE = 8'h00;
	localparam logic [7:0] FPG_RST_PIN_CFG = 8'h00;
	localparam logic [7:0] FPG_RST_PIN_STATE = 8'h00;
	localparam logic [7:0] FPG_RDATA_UNMAPPED = 8'h00; // answer for any other offset

endpackage
